// ===== common/cna_pkg.sv
// Constants, register map and field layout shared by the counter array design.
// Assumes one 20 MHz clock and an 8-bit register port addressed by byte.
package cna_pkg;

  // Array shape.
  localparam int NUM_MODULES = 5;
  localparam int COUNT_WIDTH = 16;

  // Register map.
  localparam logic [7:0] ADDR_RUN_FLAGS = 8'h00_C0;
  localparam logic [7:0] ADDR_MODE_CTRL = 8'h00_C1;
  localparam logic [7:0] ADDR_MODULE_MODE_BASE = 8'h00_C2;
  localparam logic [7:0] ADDR_VALUE_LOW_BASE = 8'h00_E0;
  localparam logic [7:0] ADDR_VALUE_HIGH_BASE = 8'h00_F0;
  localparam logic [7:0] ADDR_COUNT_LOW = 8'h00_E9;
  localparam logic [7:0] ADDR_COUNT_HIGH = 8'h00_F9;

  // Counter mode control fields.
  localparam int MC_IDLE_STOP_BIT = 7;
  localparam int MC_WATCHDOG_BIT = 6;
  localparam int MC_SOURCE_HI_BIT = 2;
  localparam int MC_SOURCE_LO_BIT = 1;
  localparam int MC_OVF_IRQ_BIT = 0;

  // Run and flags fields; module flags sit in bits 0 to 4.
  localparam int RF_OVF_FLAG_BIT = 7;
  localparam int RF_RUN_BIT = 6;

  // Count source encodings.
  localparam logic [1:0] SRC_OSC_DIV6 = 2'h0;
  localparam logic [1:0] SRC_OSC_DIV2 = 2'h1;
  localparam logic [1:0] SRC_TIMER0_OVF = 2'h2;
  localparam logic [1:0] SRC_EXT_INPUT = 2'h3;

  // Prescaler terminal counts.
  localparam logic [2:0] DIV_SLOW_LAST = 3'h5;

  // Reset values.
  localparam logic [7:0] RESET_MODE_CTRL = 8'h00_00;
  localparam logic [7:0] RESET_VALUE_BYTE = 8'h00_00;
  localparam logic [15:0] RESET_COUNT = 16'h0000;
  localparam logic PIN_IDLE_LEVEL = 1'b1;

  // Per-module mode bits, in register order from bit 6 down to bit 0.
  typedef struct packed {
    logic comparator_enable;
    logic capture_rising_enable;
    logic capture_falling_enable;
    logic flag_on_match;
    logic toggle_on_match;
    logic pwm_mode;
    logic module_irq_enable;
  } cna_mode_t;

  localparam cna_mode_t RESET_MODULE_MODE = 7'h00;

endpackage

// ===== core/cna_counter_array.sv
// Counter array: a 16-bit time base shared by five capture/compare modules.
// Assumes all inputs are synchronous to CLK and a single-cycle register port.
//
// Contract
// - One 16-bit time base shared by five 16-bit capture/compare modules.
// - Source select: 00 clock/6, 01 clock/2, 10 timer-0 overflow, 11 external pin.
// - Idle-stop bit set halts the time base while the processor idles.
// - Watchdog-enable bit turns the module 4 watchdog on or off.
// - Time base counts only while the run bit (bit 6) is set.
// - Overflow sets flag bit 7; interrupt only when overflow enable is set.
// - Only software clears the overflow flag.
// - Bits 0 to 4 are module flags, set by hardware, cleared by software.
// - Mode bit 0 lets the module flag raise an interrupt.
// - Mode bit 1 selects pulse width modulation.
// - Mode bit 2 toggles the module pin on each compare match.
// - Mode bit 3 sets the module flag on each compare match.
// - Mode bit 4 captures on falling edge, bit 5 on rising edge.
// - Mode bit 6 enables the comparator; no match while clear.
// - Value bytes load the time base on capture, hold compare value otherwise.
// - In modulation mode the high value byte sets the output duty cycle.
// - Each module owns one pin, in module order.
//
// Implementation choice: the strobed register port.
`timescale 1ns/1ps

module cna_counter_array (
  // Clock and reset.
  input wire logic CLK,
  input wire logic RESET,
  // Register port.
  input wire logic [7:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_WRITE,
  input wire logic REG_READ,
  output logic [7:0] REG_RDATA,
  // Count sources and processor state.
  input wire logic CPU_IDLE,
  input wire logic TIMER0_OVERFLOW,
  input wire logic EXTERNAL_COUNT_INPUT,
  // Module pins, bit n belongs to module n.
  input wire logic [4:0] MODULE_PIN_I,
  output logic [4:0] MODULE_PIN_O,
  output logic [4:0] MODULE_PIN_OE,
  // Interrupt and watchdog outputs.
  output logic ARRAY_IRQ,
  output logic WATCHDOG_EXPIRE
);

  // Returns a one-hot selection of the module whose register sits at addr.
  // Shared by all three write windows so that their decodes cannot drift apart.
  function automatic logic [4:0] module_select(input logic [7:0] addr, input logic [7:0] base);
    logic [4:0] sel;
    sel = '0;
    for (int k = 0; k < cna_pkg::NUM_MODULES; k++) begin
      if (addr == base + 8'(k)) begin
        sel[k] = 1'b1;
      end
    end
    return sel;
  endfunction

  // Control registers.
  logic idle_stop_control_q;
  logic watchdog_enable_q;
  logic [1:0] count_source_sel_q;
  logic overflow_irq_enable_q;
  logic run_control_q;
  logic overflow_flag_q;

  // Time base and prescaler.
  logic [15:0] count_q;
  logic [2:0] div_slow_q;
  logic div_fast_q;
  logic ext_prev_q;
  logic tick;
  logic advance;
  logic overflow;
  logic low_wrap;
  logic [15:0] count_next;

  // Per-module state.
  cna_pkg::cna_mode_t mode_q [5];
  logic [7:0] value_low_q [5];
  logic [7:0] value_high_q [5];
  logic [7:0] duty_q [5];
  logic [4:0] module_event_flag_q;
  logic [4:0] pin_prev_q;
  logic [4:0] pin_out_q;
  logic [4:0] match;
  logic [4:0] capture;
  logic watchdog_q;

  // Register write decodes.
  logic wr_mode_ctrl;
  logic wr_run_flags;
  logic wr_count_low;
  logic wr_count_high;
  logic [4:0] wr_module_mode;
  logic [4:0] wr_value_low;
  logic [4:0] wr_value_high;
  logic [7:0] rdata_q;

  assign wr_mode_ctrl = REG_WRITE && (REG_ADDR == cna_pkg::ADDR_MODE_CTRL);
  assign wr_run_flags = REG_WRITE && (REG_ADDR == cna_pkg::ADDR_RUN_FLAGS);
  assign wr_count_low = REG_WRITE && (REG_ADDR == cna_pkg::ADDR_COUNT_LOW);
  assign wr_count_high = REG_WRITE && (REG_ADDR == cna_pkg::ADDR_COUNT_HIGH);
  assign wr_module_mode = REG_WRITE ?
      module_select(REG_ADDR, cna_pkg::ADDR_MODULE_MODE_BASE) : 5'h0_0;
  assign wr_value_low = REG_WRITE ?
      module_select(REG_ADDR, cna_pkg::ADDR_VALUE_LOW_BASE) : 5'h0_0;
  assign wr_value_high = REG_WRITE ?
      module_select(REG_ADDR, cna_pkg::ADDR_VALUE_HIGH_BASE) : 5'h0_0;

  // Counter mode control register.
  // Bits 5 to 3 are reserved: they are neither stored nor read back.
  always_ff @(posedge CLK) begin
    if (RESET) begin
      idle_stop_control_q <= cna_pkg::RESET_MODE_CTRL[cna_pkg::MC_IDLE_STOP_BIT];
      watchdog_enable_q <= cna_pkg::RESET_MODE_CTRL[cna_pkg::MC_WATCHDOG_BIT];
      count_source_sel_q <= cna_pkg::RESET_MODE_CTRL[cna_pkg::MC_SOURCE_HI_BIT:
                                                     cna_pkg::MC_SOURCE_LO_BIT];
      overflow_irq_enable_q <= cna_pkg::RESET_MODE_CTRL[cna_pkg::MC_OVF_IRQ_BIT];
    end else if (wr_mode_ctrl) begin
      idle_stop_control_q <= REG_WDATA[cna_pkg::MC_IDLE_STOP_BIT];
      watchdog_enable_q <= REG_WDATA[cna_pkg::MC_WATCHDOG_BIT];
      count_source_sel_q <= REG_WDATA[cna_pkg::MC_SOURCE_HI_BIT:cna_pkg::MC_SOURCE_LO_BIT];
      overflow_irq_enable_q <= REG_WDATA[cna_pkg::MC_OVF_IRQ_BIT];
    end
  end

  // Run bit is plain software state.
  // Clearing it freezes the time base but leaves flags and module state alone.
  always_ff @(posedge CLK) begin
    if (RESET) begin
      run_control_q <= 1'b0;
    end else if (wr_run_flags) begin
      run_control_q <= REG_WDATA[cna_pkg::RF_RUN_BIT];
    end
  end

  // Free-running prescalers, so the first tick after a source change is prompt.
  // The cost is that the first count after a switch may come up to five clocks early;
  // stopping the array before switching does not give an exact first interval, as the prescalers keep running.
  always_ff @(posedge CLK) begin
    if (RESET) begin
      div_slow_q <= 3'h0;
      div_fast_q <= 1'b0;
      ext_prev_q <= 1'b0;
    end else begin
      div_slow_q <= (div_slow_q == cna_pkg::DIV_SLOW_LAST) ? 3'h0 : div_slow_q + 3'h1;
      div_fast_q <= ~div_fast_q;
      ext_prev_q <= EXTERNAL_COUNT_INPUT;
    end
  end

  // Count pulse selection; the external input counts on its falling edge.
  always_comb begin
    case (count_source_sel_q)
      cna_pkg::SRC_OSC_DIV6: tick = (div_slow_q == cna_pkg::DIV_SLOW_LAST);
      cna_pkg::SRC_OSC_DIV2: tick = div_fast_q;
      cna_pkg::SRC_TIMER0_OVF: tick = TIMER0_OVERFLOW;
      cna_pkg::SRC_EXT_INPUT: tick = ext_prev_q && !EXTERNAL_COUNT_INPUT;
      default: tick = 1'b0;
    endcase
  end

  // Time base advances only while running and not halted by idle.
  assign advance = tick && run_control_q && !(CPU_IDLE && idle_stop_control_q);
  assign count_next = count_q + 16'h0001;
  assign overflow = advance && (count_q == 16'hFFFF);
  assign low_wrap = advance && (count_q[7:0] == 8'hFF);

  // Time base register; software may preload either byte while it is stopped.
  // A byte write wins over a count pulse in the same cycle, so that pulse is lost.
  // Preloading while running is therefore allowed but not exact.
  always_ff @(posedge CLK) begin
    if (RESET) begin
      count_q <= cna_pkg::RESET_COUNT;
    end else if (wr_count_low) begin
      count_q[7:0] <= REG_WDATA;
    end else if (wr_count_high) begin
      count_q[15:8] <= REG_WDATA;
    end else if (advance) begin
      count_q <= count_next;
    end
  end

  // Overflow flag: hardware only sets it, and a set beats a clearing write.
  // A write to the run and flags register stores every written flag and the run bit, so software that
  // only wants to stop the array must write back the flags it wants to keep.
  always_ff @(posedge CLK) begin
    if (RESET) begin
      overflow_flag_q <= 1'b0;
    end else if (overflow) begin
      overflow_flag_q <= 1'b1;
    end else if (wr_run_flags) begin
      overflow_flag_q <= REG_WDATA[cna_pkg::RF_OVF_FLAG_BIT];
    end
  end

  // Capture/compare modules.
  for (genvar n = 0; n < cna_pkg::NUM_MODULES; n++) begin : g_module
    // Compare fires when the time base steps onto the stored value.
    // Matching on the next value shows flag and toggle in the cycle the count shows it.
    assign match[n] = mode_q[n].comparator_enable && advance &&
        (count_next == {value_high_q[n], value_low_q[n]});
    assign capture[n] =
        (mode_q[n].capture_rising_enable && !pin_prev_q[n] && MODULE_PIN_I[n]) ||
        (mode_q[n].capture_falling_enable && pin_prev_q[n] && !MODULE_PIN_I[n]);

    // Mode register.
    always_ff @(posedge CLK) begin
      if (RESET) begin
        mode_q[n] <= cna_pkg::RESET_MODULE_MODE;
      end else if (wr_module_mode[n]) begin
        mode_q[n] <= REG_WDATA[6:0];
      end
    end

    // Value bytes; a capture wins over a software write in the same cycle.
    always_ff @(posedge CLK) begin
      if (RESET) begin
        value_low_q[n] <= cna_pkg::RESET_VALUE_BYTE;
        value_high_q[n] <= cna_pkg::RESET_VALUE_BYTE;
      end else if (capture[n]) begin
        value_low_q[n] <= count_q[7:0];
        value_high_q[n] <= count_q[15:8];
      end else begin
        if (wr_value_low[n]) begin
          value_low_q[n] <= REG_WDATA;
        end
        if (wr_value_high[n]) begin
          value_high_q[n] <= REG_WDATA;
        end
      end
    end

    // Duty is reloaded from the high byte as the low byte wraps, avoiding glitches.
    // A new high byte written mid-period therefore takes effect from the start of the next period.
    always_ff @(posedge CLK) begin
      if (RESET) begin
        duty_q[n] <= cna_pkg::RESET_VALUE_BYTE;
      end else if (low_wrap) begin
        duty_q[n] <= value_high_q[n];
      end
    end

    // Module flag: set wins over a clearing write.
    always_ff @(posedge CLK) begin
      if (RESET) begin
        module_event_flag_q[n] <= 1'b0;
      end else if (capture[n] || (match[n] && mode_q[n].flag_on_match)) begin
        module_event_flag_q[n] <= 1'b1;
      end else if (wr_run_flags) begin
        module_event_flag_q[n] <= REG_WDATA[n];
      end
    end

    // Pin edge history and output level.
    // The history starts at the pins' idle level; starting low would make the first
    // cycle after reset look like a rising edge on every module.
    always_ff @(posedge CLK) begin
      if (RESET) begin
        pin_prev_q[n] <= cna_pkg::PIN_IDLE_LEVEL;
        pin_out_q[n] <= cna_pkg::PIN_IDLE_LEVEL;
      end else begin
        pin_prev_q[n] <= MODULE_PIN_I[n];
        if (mode_q[n].pwm_mode) begin
          pin_out_q[n] <= (count_q[7:0] >= duty_q[n]);
        end else if (match[n] && mode_q[n].toggle_on_match) begin
          pin_out_q[n] <= ~pin_out_q[n];
        end
      end
    end

    // The pin is driven only in output modes, leaving it free for capture.
    // A capture mode combined with an output mode captures the module's own edges.
    assign MODULE_PIN_OE[n] = mode_q[n].pwm_mode || mode_q[n].toggle_on_match;
  end

  assign MODULE_PIN_O = pin_out_q;

  // Watchdog pulse on a module 4 match while the watchdog is enabled.
  // Only the pulse is made here; whatever reset it triggers lives outside the block.
  always_ff @(posedge CLK) begin
    if (RESET) begin
      watchdog_q <= 1'b0;
    end else begin
      watchdog_q <= watchdog_enable_q && match[4];
    end
  end

  assign WATCHDOG_EXPIRE = watchdog_q;

  // Combined interrupt request, a level built from flops only.
  // It stays high until software clears the flag or its enable, so no event is lost.
  always_comb begin
    ARRAY_IRQ = overflow_flag_q && overflow_irq_enable_q;
    for (int k = 0; k < cna_pkg::NUM_MODULES; k++) begin
      ARRAY_IRQ = ARRAY_IRQ || (module_event_flag_q[k] && mode_q[k].module_irq_enable);
    end
  end

  // Read data appear in the cycle after the read strobe; unmapped reads give zero.
  // Reserved bits also read as zero, so software can mask without surprises.
  always_ff @(posedge CLK) begin
    if (RESET) begin
      rdata_q <= 8'h00;
    end else if (REG_READ) begin
      rdata_q <= 8'h00;
      if (REG_ADDR == cna_pkg::ADDR_MODE_CTRL) begin
        rdata_q[cna_pkg::MC_IDLE_STOP_BIT] <= idle_stop_control_q;
        rdata_q[cna_pkg::MC_WATCHDOG_BIT] <= watchdog_enable_q;
        rdata_q[cna_pkg::MC_SOURCE_HI_BIT:cna_pkg::MC_SOURCE_LO_BIT] <= count_source_sel_q;
        rdata_q[cna_pkg::MC_OVF_IRQ_BIT] <= overflow_irq_enable_q;
      end else if (REG_ADDR == cna_pkg::ADDR_RUN_FLAGS) begin
        rdata_q[cna_pkg::RF_OVF_FLAG_BIT] <= overflow_flag_q;
        rdata_q[cna_pkg::RF_RUN_BIT] <= run_control_q;
        rdata_q[4:0] <= module_event_flag_q;
      end else if (REG_ADDR == cna_pkg::ADDR_COUNT_LOW) begin
        rdata_q <= count_q[7:0];
      end else if (REG_ADDR == cna_pkg::ADDR_COUNT_HIGH) begin
        rdata_q <= count_q[15:8];
      end else begin
        for (int k = 0; k < cna_pkg::NUM_MODULES; k++) begin
          if (REG_ADDR == cna_pkg::ADDR_MODULE_MODE_BASE + 8'(k)) begin
            rdata_q <= {1'b0, mode_q[k]};
          end
          if (REG_ADDR == cna_pkg::ADDR_VALUE_LOW_BASE + 8'(k)) begin
            rdata_q <= value_low_q[k];
          end
          if (REG_ADDR == cna_pkg::ADDR_VALUE_HIGH_BASE + 8'(k)) begin
            rdata_q <= value_high_q[k];
          end
        end
      end
    end
  end

  assign REG_RDATA = rdata_q;

endmodule // cna_counter_array

// ===== sim/cna_asserts.sv
// Checker for the counter array: pin enables, flags and the interrupt.
// Assumes it is bound to cna_counter_array and shadows software writes.
`timescale 1ns/1ps
module cna_asserts (
  // Clock and reset.
  input wire logic CLK,
  input wire logic RESET,
  // Register port.
  input wire logic [7:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_WRITE,
  input wire logic REG_READ,
  input wire logic [7:0] REG_RDATA,
  // Pins and status.
  input wire logic [4:0] MODULE_PIN_O,
  input wire logic [4:0] MODULE_PIN_OE,
  input wire logic ARRAY_IRQ,
  input wire logic WATCHDOG_EXPIRE
);
  logic [7:0] mc_q;
  logic run_q;
  logic [4:0] drive_q;
  logic [4:0] ie_q;
  logic [7:0] seen_q;
  logic flags_rd_q;

  // Shadow what software wrote, since the design keeps its copies inside.
  always_ff @(posedge CLK) begin
    if (RESET) begin
      mc_q <= 8'h00_00;
      run_q <= 1'b0;
      drive_q <= 5'h00;
      ie_q <= 5'h00;
    end else if (REG_WRITE) begin
      if (REG_ADDR == cna_pkg::ADDR_MODE_CTRL) begin
        mc_q <= REG_WDATA;
      end
      if (REG_ADDR == cna_pkg::ADDR_RUN_FLAGS) begin
        run_q <= REG_WDATA[6];
      end
      for (int n = 0; n < 5; n++) begin
        if (REG_ADDR == cna_pkg::ADDR_MODULE_MODE_BASE + 8'(n)) begin
          drive_q[n] <= REG_WDATA[1] | REG_WDATA[2];
          ie_q[n] <= REG_WDATA[0];
        end
      end
    end
  end

  // Flags seen since software last wrote them; hardware may only add more.
  always_ff @(posedge CLK) begin
    if (RESET || (REG_WRITE && REG_ADDR == cna_pkg::ADDR_RUN_FLAGS)) begin
      seen_q <= 8'h00_00;
    end else if (flags_rd_q) begin
      seen_q <= seen_q | (REG_RDATA & 8'h00_9F);
    end
    flags_rd_q <= !RESET && REG_READ && REG_ADDR == cna_pkg::ADDR_RUN_FLAGS;
  end

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RESET);

  sequence s_flags_read;
    REG_READ && REG_ADDR == cna_pkg::ADDR_RUN_FLAGS;
  endsequence

  a_oe_from_mode: assert property (MODULE_PIN_OE == drive_q)
    else $error("pin enable does not follow mode");
  a_run_readback: assert property (s_flags_read |=> REG_RDATA[6] == run_q && !REG_RDATA[5])
    else $error("run bit readback wrong");
  a_flags_sticky: assert property (flags_rd_q |-> (REG_RDATA & seen_q) == seen_q)
    else $error("flag cleared without software");
  a_ovf_irq: assert property (flags_rd_q && REG_RDATA[7] && mc_q[0] |-> ARRAY_IRQ)
    else $error("overflow interrupt missing");
  a_module_irq: assert property (flags_rd_q && |(REG_RDATA[4:0] & ie_q) |-> ARRAY_IRQ)
    else $error("module interrupt missing");
  a_irq_enable: assert property (ARRAY_IRQ |-> mc_q[0] || |ie_q)
    else $error("interrupt with no enable");
  a_pin_source: assert property (
    ((MODULE_PIN_O ^ $past(MODULE_PIN_O)) & ~(drive_q | $past(drive_q))) == 5'h00)
    else $error("undriven pin changed");
  a_wdog_gate: assert property (WATCHDOG_EXPIRE |-> $past(mc_q[6]) ##1 !WATCHDOG_EXPIRE)
    else $error("watchdog pulse wrong");
endmodule  // cna_asserts

bind cna_counter_array cna_asserts u_asserts (.CLK, .RESET, .REG_ADDR, .REG_WDATA, .REG_WRITE,
  .REG_READ, .REG_RDATA, .MODULE_PIN_O, .MODULE_PIN_OE, .ARRAY_IRQ, .WATCHDOG_EXPIRE);

// ===== sim/cna_pin_model.sv
// Far side: five port pins with pull-ups and an external count source.
// Assumes the bench sets the outside pin levels and asks for pulses.
`timescale 1ns/1ps
module cna_pin_model (
  // Clock and bench requests.
  input wire logic clk,
  input wire logic [4:0] drive_level,
  input wire logic ext_run,
  // Design side.
  input wire logic [4:0] design_level,
  input wire logic [4:0] design_drive,
  output logic [4:0] pin_level,
  output logic ext_count
);
  logic [1:0] phase_q = 2'h0;
  // A pin shows the design's level while it drives, else the outside one.
  assign pin_level = (design_drive & design_level) | (~design_drive & drive_level);
  // Two cycles high, two low: never faster than a quarter of the clock.
  always_ff @(posedge clk) begin
    phase_q <= ext_run ? phase_q + 2'h1 : 2'h0;
  end
  assign ext_count = phase_q[1];
endmodule  // cna_pin_model

// ===== sim/test_programmable_counter_array.sv
// Self-checking bench for the counter array, driven through its register port.
// Assumes the pin model on the far side and the bound checker.
`timescale 1ns/1ps
module test_programmable_counter_array;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr = 8'h00_00;
  logic [7:0] wdata = 8'h00_00;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic idle = 1'b0;
  logic t0 = 1'b0;
  logic ext_run = 1'b0;
  logic [4:0] lvl = 5'h1F;
  logic [7:0] rdata;
  logic ext;
  logic [4:0] pin_i;
  logic [4:0] pin_o;
  logic [4:0] pin_oe;
  logic irq;
  logic wdog;
  int errors = 0;
  int compares = 0;
  int wd_seen = 0;
  int ones = 0;
  int lo[4] = '{7, 24, 12, 12};
  int hi[4] = '{10, 27, 12, 12};

  // 20 MHz clock.
  always #25 clk = ~clk;

  cna_counter_array u_dut (.CLK(clk), .RESET(rst), .REG_ADDR(addr), .REG_WDATA(wdata),
    .REG_WRITE(wr_en), .REG_READ(rd_en), .REG_RDATA(rdata), .CPU_IDLE(idle),
    .TIMER0_OVERFLOW(t0), .EXTERNAL_COUNT_INPUT(ext), .MODULE_PIN_I(pin_i),
    .MODULE_PIN_O(pin_o), .MODULE_PIN_OE(pin_oe), .ARRAY_IRQ(irq), .WATCHDOG_EXPIRE(wdog));
  cna_pin_model u_pins (.clk(clk), .drive_level(lvl), .ext_run(ext_run), .design_level(pin_o),
    .design_drive(pin_oe), .pin_level(pin_i), .ext_count(ext));

  // Watchdog pulses last one cycle, so they are counted as they pass.
  always @(posedge clk) begin
    if (wdog === 1'b1) begin
      wd_seen++;
    end
  end

  task automatic check(input logic [15:0] got, input logic [15:0] l, input logic [15:0] h);
    compares++;
    if ($isunknown(got) || got < l || got > h) begin
      errors++;
      $display("unexpected at %0t: got %h, want %h to %h", $time, got, l, h);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask

  // Read data appear in the cycle after the strobe and hold until the next read; sample mid-cycle.
  task automatic reg_in(input logic [7:0] a, input logic [7:0] l, input logic [7:0] h);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    @(negedge clk);
    check({8'h00, rdata}, {8'h00, l}, {8'h00, h});
  endtask

  task automatic reg_is(input logic [7:0] a, input logic [7:0] e);
    reg_in(a, e, e);
  endtask

  // Count pulses from every source at once; only the selected one counts.
  task automatic pulse(input int n);
    ext_run <= 1'b1;
    repeat (n) begin
      t0 <= 1'b1;
      @(posedge clk);
      t0 <= 1'b0;
      repeat (3) @(posedge clk);
    end
    ext_run <= 1'b0;
    repeat (2) @(posedge clk);
  endtask

  task automatic count_run(input logic [7:0] mode, input int n);
    wr(cna_pkg::ADDR_COUNT_LOW, 8'h00_00);
    wr(cna_pkg::ADDR_COUNT_HIGH, 8'h00_00);
    wr(cna_pkg::ADDR_MODE_CTRL, mode);
    wr(cna_pkg::ADDR_RUN_FLAGS, 8'h00_40);
    pulse(n);
    wr(cna_pkg::ADDR_RUN_FLAGS, 8'h00_00);
    repeat (10) @(posedge clk);
  endtask

  task automatic give_verdict();
    $display("compares %0d, errors %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // A hung run counts as a mismatch and still reaches the verdict.
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    $display("unexpected at %0t: run timed out", $time);
    give_verdict();
  end

  // Scenarios in order; each ends with one progress line.
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    reg_is(cna_pkg::ADDR_MODE_CTRL, 8'h00_00);
    check(16'(pin_o), 16'h001F, 16'h001F);
    wr(cna_pkg::ADDR_MODULE_MODE_BASE, 8'h00_FF);
    reg_is(cna_pkg::ADDR_MODULE_MODE_BASE, 8'h00_7F);
    wr(cna_pkg::ADDR_MODULE_MODE_BASE, 8'h00_00);
    wr(cna_pkg::ADDR_RUN_FLAGS, 8'h00_20);
    reg_is(cna_pkg::ADDR_RUN_FLAGS, 8'h00_00);
    wr(8'h00_D5, 8'h00_FF);
    reg_is(8'h00_D5, 8'h00_00);
    $display("test done: reset values");
    for (int s = 0; s < 4; s++) begin
      count_run({5'h00, 2'(s), 1'b0}, 12);
      reg_is(cna_pkg::ADDR_COUNT_HIGH, 8'h00_00);
      reg_in(cna_pkg::ADDR_COUNT_LOW, 8'(lo[s]), 8'(hi[s]));
      // Read data must still stand a cycle later, until the next read.
      @(negedge clk);
      check({8'h00, rdata}, 16'(lo[s]), 16'(hi[s]));
    end
    @(posedge clk);
    idle <= 1'b1;
    count_run(8'h00_82, 5);
    reg_is(cna_pkg::ADDR_COUNT_LOW, 8'h00_00);
    @(posedge clk);
    idle <= 1'b0;
    $display("test done: count sources");
    wr(cna_pkg::ADDR_COUNT_LOW, 8'h00_FE);
    wr(cna_pkg::ADDR_COUNT_HIGH, 8'h00_FF);
    wr(cna_pkg::ADDR_MODE_CTRL, 8'h00_05);
    wr(cna_pkg::ADDR_RUN_FLAGS, 8'h00_40);
    pulse(3);
    reg_is(cna_pkg::ADDR_RUN_FLAGS, 8'h00_C0);
    check(16'(irq), 16'h0001, 16'h0001);
    wr(cna_pkg::ADDR_MODE_CTRL, 8'h00_04);
    reg_is(cna_pkg::ADDR_RUN_FLAGS, 8'h00_C0);
    check(16'(irq), 16'h0000, 16'h0000);
    $display("test done: overflow");
    for (int n = 0; n < 5; n++) begin
      wr(cna_pkg::ADDR_VALUE_LOW_BASE + 8'(n), 8'h00_05);
      wr(cna_pkg::ADDR_VALUE_HIGH_BASE + 8'(n), 8'h00_00);
    end
    wr(cna_pkg::ADDR_MODULE_MODE_BASE + 8'h00_01, 8'h00_4D);
    wr(cna_pkg::ADDR_MODULE_MODE_BASE + 8'h00_02, 8'h00_0D);
    wr(cna_pkg::ADDR_MODULE_MODE_BASE + 8'h00_04, 8'h00_48);
    // The array stays running here: timer 0 is idle, so the preload loses no count pulse.
    wr(cna_pkg::ADDR_COUNT_LOW, 8'h00_00);
    wr(cna_pkg::ADDR_COUNT_HIGH, 8'h00_00);
    wr(cna_pkg::ADDR_MODE_CTRL, 8'h00_44);
    wr(cna_pkg::ADDR_RUN_FLAGS, 8'h00_40);
    pulse(6);
    @(negedge clk);
    check(16'(pin_o), 16'h001D, 16'h001D);
    check(16'(irq), 16'h0001, 16'h0001);
    check(16'(wd_seen), 16'h0001, 16'h0001);
    reg_is(cna_pkg::ADDR_RUN_FLAGS, 8'h00_52);
    wr(cna_pkg::ADDR_MODULE_MODE_BASE + 8'h00_01, 8'h00_4C);
    // Stop the array and write back the two flags so that they survive.
    wr(cna_pkg::ADDR_RUN_FLAGS, 8'h00_12);
    @(negedge clk);
    check(16'(irq), 16'h0000, 16'h0000);
    $display("test done: compare");
    wr(cna_pkg::ADDR_RUN_FLAGS, 8'h00_00);
    wr(cna_pkg::ADDR_COUNT_LOW, 8'h00_34);
    wr(cna_pkg::ADDR_COUNT_HIGH, 8'h00_12);
    wr(cna_pkg::ADDR_MODULE_MODE_BASE, 8'h00_20);
    wr(cna_pkg::ADDR_MODULE_MODE_BASE + 8'h00_03, 8'h00_30);
    lvl <= 5'h16;
    repeat (3) @(posedge clk);
    reg_is(cna_pkg::ADDR_RUN_FLAGS, 8'h00_08);
    lvl <= 5'h17;
    repeat (3) @(posedge clk);
    reg_is(cna_pkg::ADDR_RUN_FLAGS, 8'h00_09);
    reg_is(cna_pkg::ADDR_VALUE_LOW_BASE, 8'h00_34);
    reg_is(cna_pkg::ADDR_VALUE_HIGH_BASE + 8'h00_03, 8'h00_12);
    $display("test done: capture");
    wr(cna_pkg::ADDR_MODULE_MODE_BASE + 8'h00_02, 8'h00_02);
    wr(cna_pkg::ADDR_VALUE_HIGH_BASE + 8'h00_02, 8'h00_C0);
    wr(cna_pkg::ADDR_MODE_CTRL, 8'h00_02);
    wr(cna_pkg::ADDR_RUN_FLAGS, 8'h00_40);
    repeat (600) @(posedge clk);
    repeat (1024) begin
      @(negedge clk);
      ones += (pin_o[2] === 1'b1) ? 1 : 0;
    end
    check(16'(ones), 16'h00E0, 16'h0120);
    check(16'(pin_oe), 16'h0006, 16'h0006);
    $display("test done: pwm");
    give_verdict();
  end
endmodule  // test_programmable_counter_array
